/* File: shared/dtc_pkg.sv */
/*
  dtc_pkg: register map, bit positions, reset values and mode
  encoding of the dual timer/counter block.
  assumes an 8-bit special function register address and data space.
*/
`default_nettype none

package dtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_CTL  = 8'h88;  // timer_run_flag_control
  localparam logic [7:0] ADDR_MODE = 8'h89;  // timer_mode_config
  localparam logic [7:0] ADDR_T0L  = 8'h8a;  // timer0_count_low
  localparam logic [7:0] ADDR_T1L  = 8'h8b;  // timer1_count_low
  localparam logic [7:0] ADDR_T0H  = 8'h8c;  // timer0_count_high
  localparam logic [7:0] ADDR_T1H  = 8'h8d;  // timer1_count_high

  ////////////////////////////////////////////////////////////////////////////
  // control register bit positions
  localparam int unsigned BIT_TF1 = 7;
  localparam int unsigned BIT_TR1 = 6;
  localparam int unsigned BIT_TF0 = 5;
  localparam int unsigned BIT_TR0 = 4;
  localparam int unsigned BIT_IE1 = 3;
  localparam int unsigned BIT_IT1 = 2;
  localparam int unsigned BIT_IE0 = 1;
  localparam int unsigned BIT_IT0 = 0;

  ////////////////////////////////////////////////////////////////////////////
  // mode register layout: one nibble per timer
  localparam int unsigned T1_NIB_LSB = 4;
  localparam int unsigned T0_NIB_LSB = 0;
  localparam int unsigned NIB_GATE   = 3;
  localparam int unsigned NIB_CT     = 2;
  localparam int unsigned NIB_MODE   = 0;
  localparam int unsigned MODE_W     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [3:0] PIN_RST   = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // counter field limits
  localparam logic [4:0] LOW5_FULL = 5'h1f;
  localparam logic [7:0] BYTE_FULL = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // timer modes, in mode-field order
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } dtc_mode_t;

endpackage

`default_nettype wire

/* File: core/dtc_timer.sv */
/*
  dtc_timer: one timer/counter with its low and high count bytes.
  assumes the count edge and gate pin are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module dtc_timer #(
  parameter bit ALLOW_SPLIT = 1'b0
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // control
  input  wire logic              run,
  input  wire logic              gate,
  input  wire logic              gate_pin_high,
  input  wire logic              count_sel,
  input  wire logic              count_edge,
  input  wire dtc_pkg::dtc_mode_t mode,
  input  wire logic              alt_run,
  // software load
  input  wire logic              wr_low,
  input  wire logic              wr_high,
  input  wire logic [7:0]        wdata,
  // state
  output wire logic [7:0]        count_low,
  output wire logic [7:0]        count_high,
  output wire logic              ovf,
  output wire logic              ovf_alt
);
  import dtc_pkg::*;

  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;
  logic       ovf_c;
  logic       ovf_alt_c;

  ////////////////////////////////////////////////////////////////////////////
  // count enable
  wire tick      = count_sel ? count_edge : 1'b1;
  wire inc       = run & (~gate | gate_pin_high) & tick;
  wire low5_full = (low_reg[4:0] == LOW5_FULL);
  wire low_full  = (low_reg == BYTE_FULL);
  wire high_full = (high_reg == BYTE_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // next count
  always_comb begin
    low_next  = low_reg;
    high_next = high_reg;
    ovf_c     = 1'b0;
    ovf_alt_c = 1'b0;
    unique case (mode)
      MODE_13BIT: begin
        if (inc) begin
          low_next = {low_reg[7:5], low_reg[4:0] + 5'h01};
          if (low5_full) begin
            high_next = high_reg + 8'h01;
            ovf_c     = high_full;
          end
        end
      end
      MODE_16BIT: begin
        if (inc) begin
          low_next = low_reg + 8'h01;
          if (low_full) begin
            high_next = high_reg + 8'h01;
            ovf_c     = high_full;
          end
        end
      end
      MODE_RELOAD8: begin
        if (inc) begin
          low_next = low_full ? high_reg : low_reg + 8'h01;
          ovf_c    = low_full;
        end
      end
      MODE_SPLIT: begin
        if (ALLOW_SPLIT) begin
          if (inc) begin
            low_next = low_reg + 8'h01;
            ovf_c    = low_full;
          end
          if (alt_run) begin
            high_next = high_reg + 8'h01;
            ovf_alt_c = high_full;
          end
        end
      end
    endcase
    if (wr_low) begin
      low_next = wdata;
    end
    if (wr_high) begin
      high_next = wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      low_reg  <= COUNT_RST;
      high_reg <= COUNT_RST;
    end else begin
      low_reg  <= low_next;
      high_reg <= high_next;
    end
  end

  assign count_low  = low_reg;
  assign count_high = high_reg;
  assign ovf        = ovf_c;
  assign ovf_alt    = ovf_alt_c;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  mode0_top_a: assert property (
    mode == MODE_13BIT && !wr_low |=> $stable(low_reg[7:5]))
    else $error("mode 0 touched the unused low bits");

  mode0_carry_a: assert property (
    mode == MODE_13BIT && inc && low5_full && !low_full && !wr_low && !wr_high
    |=> high_reg == $past(high_reg) + 8'h01)
    else $error("mode 0 carry did not reach the high byte at five bits");

  mode1_wrap_a: assert property (
    mode == MODE_16BIT && inc && low_full && high_full |-> ovf
    ##1 (low_reg == 8'h00 || $past(wr_low)))
    else $error("mode 1 wrap missed its overflow");

  idle_hold_a: assert property (
    !inc && !alt_run && !wr_low && !wr_high
    |=> $stable(low_reg) && $stable(high_reg))
    else $error("count moved without a count enable");

endmodule

`default_nettype wire

/* File: core/dtc_core.sv */
/*
  dtc_core: two timer/counters with their shared run/flag control
  register, the mode register and the external interrupt request flags.
  assumes a single-cycle register port from the core, vector pulses from
  the interrupt controller on clk_sys, and asynchronous external pins.
*/
// The implementer's own choice: the plain strobed port.
// Notes on behaviour
// - timer one overflow sets control bit 7; in timer zero split mode the timer zero high byte overflow sets it
// - timer one overflow flag clears when its service routine is vectored
// - timer zero overflow sets bit 5, cleared on vectoring
// - bit 6 runs timer one; zero stops it unless timer zero is in split mode
// - bit 4 runs timer zero; zero stops it, except the timer zero high byte in split mode, which bit 6 runs
// - pin b falling edge or low level sets request flag bit 3
// - pin a falling edge or low level sets request flag bit 1
// - edge flags clear on vectoring; level flags follow the pin
// - trigger type bits 2 and 0: one is edge, zero is level
// - the four external bits never affect the timers
// - timer zero high and low bytes at 8c and 8a
// - timer one high and low bytes at 8d and 8b
// - mode 0 counts 13 bits: high byte plus low five bits
// - wrap from all ones to zero sets the overflow flag
// - count only when run is one and gate off or pin high; in timer zero split mode bit 6 alone runs the timer zero high byte and timer one ignores bit 6
// - no prescaler: timer input advances every core clock
// - setting run leaves the count untouched
// - mode 1 is mode 0 with all sixteen bits
// - both timers behave alike with their own bits and pins, except split mode, which only timer zero has
// - two-bit mode field picks 13-bit, 16-bit, reload or split mode
// - timer function increments once per core clock
// - counter function counts sampled high-then-low transitions of its pin
// - counter select picks the count pin, else the core clock
`timescale 1ns/1ps
`default_nettype none

module dtc_core (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // register port
  input  wire logic [dtc_pkg::ADDR_W-1:0] sfr_addr,
  input  wire logic [dtc_pkg::DATA_W-1:0] sfr_wdata,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  output wire logic [dtc_pkg::DATA_W-1:0] sfr_rdata,
  // vectoring pulses
  input  wire logic                   vec_tmr0,
  input  wire logic                   vec_tmr1,
  input  wire logic                   vec_ext_a,
  input  wire logic                   vec_ext_b,
  // external pins
  input  wire logic                   ext_irq_pin_a,
  input  wire logic                   ext_irq_pin_b,
  input  wire logic                   count_pin_zero,
  input  wire logic                   count_pin_one,
  // request flags
  output wire logic                   timer_zero_overflow_flag,
  output wire logic                   timer_one_overflow_flag,
  output wire logic                   ext_irq_a_request_flag,
  output wire logic                   ext_irq_b_request_flag
);
  import dtc_pkg::*;

  localparam int unsigned PIN_A  = 0;
  localparam int unsigned PIN_B  = 1;
  localparam int unsigned PIN_C0 = 2;
  localparam int unsigned PIN_C1 = 3;

  logic [7:0] ctl_reg;
  logic [7:0] mode_reg;
  logic [7:0] rdata_reg;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] pin_lvl_reg;
  logic [3:0] pin_prev_reg;
  wire  [7:0] ctl_next;
  wire  [7:0] t0_low;
  wire  [7:0] t0_high;
  wire  [7:0] t1_low;
  wire  [7:0] t1_high;
  wire        t0_ovf;
  wire        t0_ovf_alt;
  wire        t1_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic flag_upd(input logic cur, input logic set,
                                    input logic clr, input logic wr,
                                    input logic wbit);
    flag_upd = set | (wr ? wbit : (cur & ~clr));
  endfunction

  function automatic logic [3:0] settle(input logic [3:0] lvl,
                                        input logic [3:0] a,
                                        input logic [3:0] b);
    settle = (a & b) | (lvl & (a ^ b));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  wire [3:0] pin_raw  = {count_pin_one, count_pin_zero, ext_irq_pin_b, ext_irq_pin_a};
  wire [3:0] lvl_next = settle(pin_lvl_reg, pin_s2_reg, pin_s3_reg);
  wire [3:0] pin_fall = pin_prev_reg & ~pin_lvl_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1_reg   <= PIN_RST;
      pin_s2_reg   <= PIN_RST;
      pin_s3_reg   <= PIN_RST;
      pin_lvl_reg  <= PIN_RST;
      pin_prev_reg <= PIN_RST;
    end else begin
      pin_s1_reg   <= pin_raw;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      pin_lvl_reg  <= lvl_next;
      pin_prev_reg <= pin_lvl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_ctl  = sfr_wr && (sfr_addr == ADDR_CTL);
  wire wr_mode = sfr_wr && (sfr_addr == ADDR_MODE);
  wire wr_t0l  = sfr_wr && (sfr_addr == ADDR_T0L);
  wire wr_t0h  = sfr_wr && (sfr_addr == ADDR_T0H);
  wire wr_t1l  = sfr_wr && (sfr_addr == ADDR_T1L);
  wire wr_t1h  = sfr_wr && (sfr_addr == ADDR_T1H);

  wire [7:0] rd_mux =
    (sfr_addr == ADDR_CTL)  ? ctl_reg  :
    (sfr_addr == ADDR_MODE) ? mode_reg :
    (sfr_addr == ADDR_T0L)  ? t0_low   :
    (sfr_addr == ADDR_T0H)  ? t0_high  :
    (sfr_addr == ADDR_T1L)  ? t1_low   :
    (sfr_addr == ADDR_T1H)  ? t1_high  : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // mode field decode
  wire [3:0] t0_nib = mode_reg[T0_NIB_LSB +: 4];
  wire [3:0] t1_nib = mode_reg[T1_NIB_LSB +: 4];
  wire dtc_mode_t t0_mode = dtc_mode_t'(t0_nib[NIB_MODE +: MODE_W]);
  wire dtc_mode_t t1_mode = dtc_mode_t'(t1_nib[NIB_MODE +: MODE_W]);
  wire t0_split = (t0_mode == MODE_SPLIT);
  wire tr0      = ctl_reg[BIT_TR0];
  wire tr1      = ctl_reg[BIT_TR1];
  // timer one keeps running while timer zero borrows its run bit
  wire t1_run   = t0_split ? 1'b1 : tr1;
  wire tf1_set  = t0_split ? t0_ovf_alt : t1_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  dtc_timer #(
    .ALLOW_SPLIT (1'b1)
  ) u_timer0 (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .run           (tr0),
    .gate          (t0_nib[NIB_GATE]),
    .gate_pin_high (pin_lvl_reg[PIN_A]),
    .count_sel     (t0_nib[NIB_CT]),
    .count_edge    (pin_fall[PIN_C0]),
    .mode          (t0_mode),
    .alt_run       (tr1),
    .wr_low        (wr_t0l),
    .wr_high       (wr_t0h),
    .wdata         (sfr_wdata),
    .count_low     (t0_low),
    .count_high    (t0_high),
    .ovf           (t0_ovf),
    .ovf_alt       (t0_ovf_alt)
  );

  dtc_timer #(
    .ALLOW_SPLIT (1'b0)
  ) u_timer1 (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .run           (t1_run),
    .gate          (t1_nib[NIB_GATE]),
    .gate_pin_high (pin_lvl_reg[PIN_B]),
    .count_sel     (t1_nib[NIB_CT]),
    .count_edge    (pin_fall[PIN_C1]),
    .mode          (t1_mode),
    .alt_run       (1'b0),
    .wr_low        (wr_t1l),
    .wr_high       (wr_t1h),
    .wdata         (sfr_wdata),
    .count_low     (t1_low),
    .count_high    (t1_high),
    .ovf           (t1_ovf),
    .ovf_alt       ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register next value; hardware set wins over any clear
  wire it0      = ctl_reg[BIT_IT0];
  wire it1      = ctl_reg[BIT_IT1];
  wire a_low    = ~pin_lvl_reg[PIN_A];
  wire b_low    = ~pin_lvl_reg[PIN_B];
  wire ie0_set  = it0 ? pin_fall[PIN_A] : a_low;
  wire ie1_set  = it1 ? pin_fall[PIN_B] : b_low;
  wire ie0_clr  = it0 ? vec_ext_a : 1'b1;
  wire ie1_clr  = it1 ? vec_ext_b : 1'b1;

  assign ctl_next[BIT_TF1] = flag_upd(ctl_reg[BIT_TF1], tf1_set, vec_tmr1,
                                      wr_ctl, sfr_wdata[BIT_TF1]);
  assign ctl_next[BIT_TF0] = flag_upd(ctl_reg[BIT_TF0], t0_ovf, vec_tmr0,
                                      wr_ctl, sfr_wdata[BIT_TF0]);
  assign ctl_next[BIT_IE1] = flag_upd(ctl_reg[BIT_IE1], ie1_set, ie1_clr,
                                      wr_ctl, sfr_wdata[BIT_IE1]);
  assign ctl_next[BIT_IE0] = flag_upd(ctl_reg[BIT_IE0], ie0_set, ie0_clr,
                                      wr_ctl, sfr_wdata[BIT_IE0]);
  assign ctl_next[BIT_TR1] = wr_ctl ? sfr_wdata[BIT_TR1] : tr1;
  assign ctl_next[BIT_TR0] = wr_ctl ? sfr_wdata[BIT_TR0] : tr0;
  assign ctl_next[BIT_IT1] = wr_ctl ? sfr_wdata[BIT_IT1] : it1;
  assign ctl_next[BIT_IT0] = wr_ctl ? sfr_wdata[BIT_IT0] : it0;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_reg   <= CTL_RST;
      mode_reg  <= MODE_RST;
      rdata_reg <= 8'h00;
    end else begin
      ctl_reg   <= ctl_next;
      mode_reg  <= wr_mode ? sfr_wdata : mode_reg;
      rdata_reg <= sfr_rd ? rd_mux : 8'h00;
    end
  end

  assign sfr_rdata                = rdata_reg;
  assign timer_zero_overflow_flag = ctl_reg[BIT_TF0];
  assign timer_one_overflow_flag  = ctl_reg[BIT_TF1];
  assign ext_irq_a_request_flag   = ctl_reg[BIT_IE0];
  assign ext_irq_b_request_flag   = ctl_reg[BIT_IE1];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire no_t0_wr = !wr_t0l && !wr_t0h;
  wire no_t1_wr = !wr_t1l && !wr_t1h;

  tf1_set_a: assert property (tf1_set |=> ctl_reg[BIT_TF1])
    else $error("timer one overflow did not set its flag");

  tf1_clear_a: assert property (
    ctl_reg[BIT_TF1] && vec_tmr1 && !tf1_set && !wr_ctl |=> !ctl_reg[BIT_TF1])
    else $error("timer one flag survived its vector");

  tf0_flag_a: assert property (t0_ovf |=> ctl_reg[BIT_TF0])
    else $error("timer zero overflow did not set its flag");

  t1_stop_a: assert property (
    !tr1 && !t0_split && no_t1_wr |=> $stable({t1_high, t1_low}))
    else $error("timer one counted while stopped");

  t0_run_a: assert property (
    tr0 && !t0_nib[NIB_GATE] && !t0_nib[NIB_CT] && t0_mode == MODE_16BIT
    && no_t0_wr |=> {t0_high, t0_low} == $past({t0_high, t0_low}) + 16'h0001)
    else $error("timer zero did not advance once per clock");

  ext_b_edge_a: assert property (
    it1 && pin_fall[PIN_B] |=> ctl_reg[BIT_IE1])
    else $error("pin b falling edge lost");

  ext_a_level_a: assert property (
    !it0 && a_low |=> ctl_reg[BIT_IE0])
    else $error("pin a low level did not raise its flag");

  level_follow_a: assert property (
    !it0 && !a_low && !wr_ctl |=> !ctl_reg[BIT_IE0])
    else $error("level flag held after pin released");

  gate_hold_a: assert property (
    t0_nib[NIB_GATE] && !pin_lvl_reg[PIN_A] && !t0_split && no_t0_wr
    |=> $stable({t0_high, t0_low}))
    else $error("gated timer counted with pin low");

  pin_count_a: assert property (
    tr0 && t0_nib[NIB_CT] && (!t0_nib[NIB_GATE] || pin_lvl_reg[PIN_A])
    && t0_mode == MODE_16BIT && no_t0_wr |=> ($past(pin_fall[PIN_C0]) ? 16'h0001 : 16'h0000)
    == {t0_high, t0_low} - $past({t0_high, t0_low}))
    else $error("counter function miscounted pin edges");

  ext_indep_a: assert property (
    $changed(ctl_reg[BIT_IT0]) && !tr0 && no_t0_wr |=> $stable({t0_high, t0_low}))
    else $error("trigger bit moved a timer");

  read_t0l_a: assert property (
    sfr_rd && sfr_addr == ADDR_T0L |=> sfr_rdata == $past(t0_low))
    else $error("timer zero low byte read wrong");

  read_idle_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data stood outside its cycle");

  run_keep_a: assert property (
    wr_ctl && sfr_wdata[BIT_TR0] && !tr0 && no_t0_wr |=> $stable({t0_high, t0_low}))
    else $error("setting run changed the count");

  tf0_clear_a: assert property (
    ctl_reg[BIT_TF0] && vec_tmr0 && !t0_ovf && !wr_ctl |=> !ctl_reg[BIT_TF0])
    else $error("timer zero flag survived its vector");

  tf0_wrap_a: assert property (
    tr0 && !t0_nib[NIB_GATE] && !t0_nib[NIB_CT] && t0_mode == MODE_13BIT && no_t0_wr
    && t0_high == 8'hff && t0_low[4:0] == LOW5_FULL |=> ctl_reg[BIT_TF0] && t0_high == 8'h00)
    else $error("mode 0 wrap did not set the timer zero flag");

  t1_run_a: assert property (
    tr1 && !t0_split && !t1_nib[NIB_GATE] && !t1_nib[NIB_CT] && t1_mode == MODE_16BIT
    && no_t1_wr |=> {t1_high, t1_low} == $past({t1_high, t1_low}) + 16'h0001)
    else $error("timer one did not advance once per clock");

  ext_b_level_a: assert property (
    !it1 && b_low |=> ctl_reg[BIT_IE1])
    else $error("pin b low level did not raise its flag");

  ext_a_clear_a: assert property (
    it0 && vec_ext_a && !pin_fall[PIN_A] && !wr_ctl |=> !ctl_reg[BIT_IE0])
    else $error("edge flag survived its vector");

  edge_hold_a: assert property (
    it0 && !pin_fall[PIN_A] && !vec_ext_a && !wr_ctl |=> $stable(ctl_reg[BIT_IE0]))
    else $error("edge-mode flag moved without an edge");

  read_ctl_a: assert property (
    sfr_rd && sfr_addr == ADDR_CTL |=> sfr_rdata == $past(ctl_reg))
    else $error("control register read wrong");

  read_mode_a: assert property (
    sfr_rd && sfr_addr == ADDR_MODE |=> sfr_rdata == $past(mode_reg))
    else $error("mode register read wrong");

  tf0_cov: cover property (t0_ovf ##1 ctl_reg[BIT_TF0]);
  tf1_cov: cover property (tf1_set ##1 vec_tmr1 ##1 !ctl_reg[BIT_TF1]);
  edge_cov: cover property (it0 && pin_fall[PIN_A] ##1 ctl_reg[BIT_IE0]);
  split_cov: cover property (t0_split && t0_ovf_alt);
  level_cov: cover property (!it1 && b_low ##1 ctl_reg[BIT_IE1]);

endmodule

`default_nettype wire

/* File: test/dtc_core_model.sv */
/*
  dtc_core_model: processor-side stand-in that vectors to service routines.
  assumes request flags on clk_sys; lat sets the answer delay in cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module dtc_core_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // requests and vectors
  input  wire logic [3:0] flag,
  input  wire logic [3:0] ack_en,
  input  wire logic [3:0] lat,
  output var  logic [3:0] vec
);
  logic [3:0] cnt_reg [4];
  logic [3:0] done_reg;

  // one vector pulse per request, rearmed once the flag drops
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      vec[i] <= rst_n && flag[i] && ack_en[i] && !done_reg[i]
                && cnt_reg[i] == lat;
      if (!rst_n || !flag[i] || !ack_en[i]) begin
        cnt_reg[i] <= 4'h0;
        done_reg[i] <= 1'b0;
      end else if (!done_reg[i] && cnt_reg[i] == lat) begin
        done_reg[i] <= 1'b1;
      end else if (!done_reg[i]) begin
        cnt_reg[i] <= cnt_reg[i] + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* File: test/dtc_core_tb_top.sv */
/*
  dtc_core_tb_top: self-checking bench of the dual timer/counter block.
  assumes the register port and vector pulses described for dtc_core.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module dtc_core_tb_top;
  import dtc_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [1:0] pin_ext = 2'h3;
  logic [1:0] pin_cnt = 2'h3;
  logic [3:0] ack_en = 4'h0;
  logic [3:0] lat = 4'h2;
  logic [7:0] d;
  wire  logic [7:0] sfr_rdata;
  wire  logic [3:0] flg;
  wire  logic [3:0] vec;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;

  dtc_core i_dtc_core (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .vec_tmr0(vec[0]), .vec_tmr1(vec[1]), .vec_ext_a(vec[2]), .vec_ext_b(vec[3]),
    .ext_irq_pin_a(pin_ext[0]), .ext_irq_pin_b(pin_ext[1]),
    .count_pin_zero(pin_cnt[0]), .count_pin_one(pin_cnt[1]),
    .timer_zero_overflow_flag(flg[0]), .timer_one_overflow_flag(flg[1]),
    .ext_irq_a_request_flag(flg[2]), .ext_irq_b_request_flag(flg[3]));

  dtc_core_model i_dtc_core_model (.clk_sys(clk_sys), .rst_n(rst_n), .flag(flg),
    .ack_en(ack_en), .lat(lat), .vec(vec));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    d = sfr_rdata;
  endtask

  task automatic wait_flg(input int i, input logic v);
    for (int k = 0; k < 20 && flg[i] !== v; k++) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic regs();
    for (logic [7:0] a = 8'h88; a < 8'h8f; a++) begin
      rd(a);
      `CHK(d, 8'h00)
    end
    wr(8'h8e, 8'hff);
    rd(8'h8e);
    `CHK(d, 8'h00)
    for (logic [7:0] a = 8'h8a; a < 8'h8e; a++) wr(a, a + 8'h10);
    for (logic [7:0] a = 8'h8a; a < 8'h8e; a++) begin
      rd(a);
      `CHK(d, a + 8'h10)
    end
    wr(ADDR_CTL, 8'haf);
    rd(ADDR_CTL);
    `CHK(d, 8'haf)
    `CHK(flg, 4'hf)
    wr(ADDR_CTL, 8'h00);
    $display("test regs done");
  endtask

  task automatic tmr(input int t, input logic [1:0] m);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = t ? ADDR_T1L : ADDR_T0L;
    hi = t ? ADDR_T1H : ADDR_T0H;
    wr(ADDR_MODE, t ? {2'b00, m, 4'h0} : {6'h00, m});
    wr(hi, 8'hff);
    wr(lo, m[0] ? 8'hff : 8'h1f);
    wr(ADDR_CTL, t ? 8'h40 : 8'h10);
    @(posedge clk_sys);
    #1;
    `CHK(flg[t], 1'b1)
    wr(ADDR_CTL, t ? 8'h80 : 8'h20);
    rd(hi);
    `CHK(d, 8'h00)
    rd(lo);
    `CHK(d & (m[0] ? 8'hff : 8'h1f), 8'h02)
    rd(lo);
    `CHK(d & (m[0] ? 8'hff : 8'h1f), 8'h02)
    ack_en[t] <= 1'b1;
    wait_flg(t, 1'b0);
    `CHK(flg[t], 1'b0)
    ack_en[t] <= 1'b0;
    $display("test timer %0d mode %0d done", t, m);
  endtask

  task automatic ext(input int p, input logic edg);
    wr(ADDR_CTL, edg ? (p ? 8'h04 : 8'h01) : 8'h00);
    pin_ext[p] <= 1'b0;
    wait_flg(2 + p, 1'b1);
    `CHK(flg[2 + p], 1'b1)
    if (edg) begin
      ack_en[2 + p] <= 1'b1;
      wait_flg(2 + p, 1'b0);
      repeat (8) @(posedge clk_sys);
      `CHK(flg[2 + p], 1'b0)
      ack_en[2 + p] <= 1'b0;
    end
    @(posedge clk_sys);
    pin_ext[p] <= 1'b1;
    wait_flg(2 + p, 1'b0);
    `CHK(flg[2 + p], 1'b0)
    rd(ADDR_T0L);
    `CHK(d, 8'h02)
    $display("test ext %0d edge %0d done", p, edg);
  endtask

  task automatic pulses();
    repeat (3) begin
      @(posedge clk_sys);
      pin_cnt[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pin_cnt[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic cnt();
    pin_ext[0] <= 1'b0;
    wr(ADDR_MODE, 8'h0d);
    wr(ADDR_T0L, 8'h00);
    wr(ADDR_CTL, 8'h10);
    pulses();
    rd(ADDR_T0L);
    `CHK(d, 8'h00)
    pin_ext[0] <= 1'b1;
    pulses();
    rd(ADDR_T0L);
    `CHK(d, 8'h03)
    wr(ADDR_CTL, 8'h00);
    $display("test counter done");
  endtask

  task automatic rld();
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_T0H, 8'hf0);
    wr(ADDR_T0L, 8'hff);
    wr(ADDR_CTL, 8'h10);
    wr(ADDR_CTL, 8'h20);
    rd(ADDR_T0L);
    `CHK(d, 8'hf1)
    rd(ADDR_T0H);
    `CHK(d, 8'hf0)
    `CHK(flg[0], 1'b1)
    wr(ADDR_CTL, 8'h00);
    $display("test reload done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    regs();
    for (int t = 0; t < 2; t++) for (int m = 0; m < 2; m++) tmr(t, m[1:0]);
    for (int e = 1; e >= 0; e--) for (int p = 0; p < 2; p++) ext(p, e[0]);
    cnt();
    rld();
    finish_test();
  end
endmodule

`default_nettype wire
